// ---- logic/timing_io.sv ----
// Counter/timer block with acquisition trigger gate and trigger-bus crossbar.
// Assumes host strobes are one-cycle pulses on ref_clk; pins arrive asynchronously.
//
// Overview of operation
// R1 - Counter input from timebase, pin, previous output
// R2 - Count on rising or falling edge
// R3 - Five gate modes start and stop counting
// R4 - Level gating by neighbour counter gates
// R5 - Output may be high-impedance or low
// R6 - Rollover gives terminal count, optional reload
// R7 - Pulse mode: one-cycle pulse at TC
// R8 - Toggle mode: output flips at TC
// R9 - Output polarity true or inverted
// R10 - Trigger fall or start write sets gate
// R11 - Sample end, errors, clear write clear gate
// R12 - Counters 3 and 4 serve acquisition timing
// R13 - Host tri-states shared convert line properly
// R14 - Counter 5 cascades with 4 for 32 bits
// R15 - Counter 1 divides scan clock for list
// R16 - Counter 2 marks the scan interval
// R17 - Frequency output divides source by 4-bit value
// R18 - Update pulse refreshes analog outputs when enabled
// R19 - Falling update edge raises request when selected
// R20 - 7x7 crossbar between board and bus lines
// R21 - Crossbar loaded via shift and strobe bytes
// R22 - Counter 5 source taken from crossbar
// R23 - Five 16-bit counters, divider, timebases
// R24 - Counter clock is board clock over ten
// R25 - Strobe moves shifted pattern active at once
// R26 - Trigger synchronised; clear beats set
`timescale 1ns/10ps
module timing_io
  import timing_io_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int COUNTERS = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Host register port
  input wire logic [4:0] io_addr,
  input wire logic [15:0] io_wdata,
  input wire logic io_write,
  input wire logic io_read,
  output logic [15:0] io_rdata,
  // Acquisition control levels and events
  input wire logic acq_enable,
  input wire logic sample_count_32,
  input wire logic scan_divide,
  input wire logic waveform_gen_enable,
  input wire logic update_request_mode,
  input wire logic overflow_err,
  input wire logic overrun_err,
  input wire logic scan_pacing_clock,
  input wire logic acq_gate3,
  // Connector pins
  input wire logic ext_trigger_n,
  input wire logic [1:0] source_pin,
  input wire logic [2:0] gate_pin,
  output logic [COUNTERS-1:0] counter_out,
  output logic [COUNTERS-1:0] counter_out_oe,
  output logic divided_frequency_out,
  // Acquisition timing outputs
  output logic counter4_gate,
  output logic channel_list_clock,
  output logic analog_update,
  output logic update_request,
  // Trigger bus lines
  input wire logic [XBAR_LINES-1:0] trig_bus_in,
  output logic [XBAR_LINES-1:0] trig_bus_out,
  output logic [XBAR_LINES-1:0] trig_bus_oe
);
  localparam int SYNC_W = 13;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_CYCLES - 1);
  localparam logic [3:0] PRESCALE_HALF = 4'(PRESCALE_CYCLES / 2);
  localparam logic [3:0] DECADE_LAST = 4'(DECADE_RATIO - 1);
  localparam logic [3:0] DECADE_HALF = 4'(DECADE_RATIO / 2);
  localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic trig_prev;
    logic [3:0] prescale;
    logic [3:0][3:0] decade;
    logic div2;
    logic [COUNTERS-1:0][WIDTH-1:0] count;
    logic [COUNTERS-1:0][WIDTH-1:0] load;
    logic [COUNTERS-1:0][15:0] mode;
    logic [COUNTERS-1:0] armed;
    logic [COUNTERS-1:0] run_edge;
    logic [COUNTERS-1:0] tgl;
    logic [COUNTERS-1:0] in_prev;
    logic [COUNTERS-1:0] gate_prev;
    logic [COUNTERS-1:0] out;
    logic [COUNTERS-1:0] oe;
    logic [2:0] ptr;
    logic [1:0] dsel;
    logic [3:0] freq_src;
    logic [3:0] freq_div;
    logic [3:0] freq_cnt;
    logic freq_prev;
    logic freq_out;
    logic gate_ff;
    logic [XBAR_CFG_BITS-1:0] xshift;
    logic [XBAR_CFG_BITS-1:0] xcfg;
    logic [XBAR_LINES-1:0] bus_out;
    logic [XBAR_LINES-1:0] bus_oe;
    logic upd_prev;
    logic analog_update;
    logic update_request;
    logic list_clk;
    logic [15:0] rdata;
  } state_t;

  state_t s, next_s;
  logic [COUNTERS-1:0] tc;
  logic gate_set, gate_clr, trig_fall;

  always_comb begin
    logic [4:0] tb;
    logic [4:0] srcs, gates;
    logic [15:0] invec;
    logic [14:0] fvec;
    logic carry, cur, edge_hit, g, run, raw, lvl, wr, fcur;
    logic [4:0] fdiv;
    logic [6:0] a_sig, a_in;
    logic [2:0] sel;
    logic [XBAR_LINES-1:0] bus_s;
    logic upd_n, upd_fall;
    logic [15:0] rd;
    gate_mode_t gm;
    out_ctl_t oc;
    int nx, pv;
    tb = '0;
    srcs = '0;
    gates = '0;
    invec = '0;
    fvec = '0;
    {carry, cur, edge_hit, g, run, raw, lvl, wr, fcur} = '0;
    fdiv = '0;
    a_sig = '0;
    a_in = '0;
    sel = '0;
    bus_s = '0;
    upd_n = 1'b1;
    upd_fall = 1'b0;
    rd = '0;
    gm = GATE_NONE;
    oc = OUT_NORMAL;
    nx = 0;
    pv = 0;
    next_s = s;
    tc = '0;
    wr = io_write;
    // Pin synchronisers
    next_s.sync1 = {trig_bus_in, gate_pin, source_pin, ext_trigger_n};
    next_s.sync2 = s.sync1;
    bus_s = s.sync2[12:6];
    // Timebases: counter clock at one tenth of board clock, then decades
    next_s.div2 = ~s.div2; // [R24]
    carry = (s.prescale == PRESCALE_LAST);
    next_s.prescale = carry ? 4'h0 : s.prescale + 4'h1; // [R24]
    tb[0] = (s.prescale < PRESCALE_HALF);
    for (int k = 0; k < 4; k++) begin
      if (carry) begin
        next_s.decade[k] = (s.decade[k] == DECADE_LAST) ? 4'h0 : s.decade[k] + 4'h1;
      end
      tb[k+1] = (s.decade[k] < DECADE_HALF);
      carry = carry & (s.decade[k] == DECADE_LAST);
    end
    // Crossbar board side: A3 feeds counter 5 source, A6 the update trigger
    for (int k = 0; k < XBAR_LINES; k++) begin
      sel = s.xcfg[XBAR_PIN_BASE + k*XBAR_FIELD +: 3];
      a_in[k] = bus_s[sel > 3'h6 ? 3'h0 : sel];
    end
    srcs[0] = s.sync2[1];
    srcs[1] = s.div2; // [R24]
    srcs[2] = scan_pacing_clock; // [R15]
    srcs[3] = 1'b0;
    srcs[4] = s.xcfg[XBAR_PIN_BASE + PIN_SRC5*XBAR_FIELD + 3] ? a_in[PIN_SRC5] : s.sync2[2]; // [R22]
    gates[0] = s.sync2[3];
    gates[1] = s.sync2[4];
    gates[2] = acq_gate3; // [R12]
    gates[3] = s.gate_ff; // [R10]
    gates[4] = s.sync2[5];
    // Counters
    for (int i = 0; i < COUNTERS; i++) begin // [R23]
      nx = (i + 1) % COUNTERS;
      pv = (i + COUNTERS - 1) % COUNTERS;
      invec = {s.out[pv], gates, srcs, tb};
      cur = invec[s.mode[i][MODE_SRC_LSB +: 4]]; // [R1]
      edge_hit = s.mode[i][MODE_EDGE_BIT] ? (s.in_prev[i] & ~cur) : (~s.in_prev[i] & cur); // [R2]
      if (i == 4 && sample_count_32) begin
        edge_hit = tc[3]; // [R14]
      end
      next_s.in_prev[i] = cur;
      g = gates[i];
      next_s.gate_prev[i] = g;
      gm = gate_mode_t'(s.mode[i][MODE_GATE_LSB +: 3]);
      unique case (gm)
        GATE_NONE: run = 1'b1; // [R3]
        GATE_HIGH: run = g; // [R3]
        GATE_LOW: run = ~g; // [R3]
        GATE_RISE: run = s.run_edge[i] | (g & ~s.gate_prev[i]); // [R3]
        GATE_FALL: run = s.run_edge[i] | (~g & s.gate_prev[i]); // [R3]
        GATE_NEXT: run = gates[nx]; // [R4]
        GATE_PREV: run = gates[pv]; // [R4]
        default: run = 1'b0;
      endcase
      if (s.armed[i] && run && edge_hit) begin
        if (s.mode[i][MODE_DOWN_BIT]) begin
          tc[i] = (s.count[i] == '0); // [R6]
          next_s.count[i] = tc[i] ? (s.mode[i][MODE_RELOAD_BIT] ? s.load[i] : ALL_ONES)
                                  : s.count[i] - 1'b1;
        end else begin
          tc[i] = (s.count[i] == ALL_ONES); // [R6]
          next_s.count[i] = tc[i] ? (s.mode[i][MODE_RELOAD_BIT] ? s.load[i] : '0)
                                  : s.count[i] + 1'b1;
        end
      end
      next_s.run_edge[i] = (gm == GATE_RISE || gm == GATE_FALL) && run && !tc[i];
      next_s.tgl[i] = s.tgl[i] ^ tc[i]; // [R8]
      raw = s.mode[i][MODE_TOGGLE_BIT] ? next_s.tgl[i] : tc[i]; // [R7]
      lvl = raw ^ s.mode[i][MODE_INVERT_BIT]; // [R9]
      oc = out_ctl_t'(s.mode[i][MODE_OUT_LSB +: 2]);
      unique case (oc)
        OUT_HIZ: begin
          next_s.out[i] = 1'b0; // [R5] [R13]
          next_s.oe[i] = 1'b0;
        end
        OUT_LOW: begin
          next_s.out[i] = 1'b0; // [R5]
          next_s.oe[i] = 1'b1;
        end
        default: begin
          next_s.out[i] = lvl;
          next_s.oe[i] = 1'b1;
        end
      endcase
    end
    // Channel list clock from counter 1 or straight from scan clock
    next_s.list_clk = scan_divide ? s.out[0] : scan_pacing_clock; // [R15]
    // Frequency output
    fvec = {gates, srcs, tb};
    fcur = (s.freq_src < 4'hF) ? fvec[s.freq_src] : 1'b0; // [R17]
    fdiv = (s.freq_div == 4'h0) ? 5'h10 : {1'b0, s.freq_div};
    next_s.freq_prev = fcur;
    if (fcur && !s.freq_prev) begin
      next_s.freq_cnt = ({1'b0, s.freq_cnt} >= fdiv - 5'h1) ? 4'h0 : s.freq_cnt + 4'h1; // [R17]
    end
    next_s.freq_out = (fdiv == 5'h1) ? fcur : ({1'b0, s.freq_cnt} < ((fdiv + 5'h1) >> 1));
    // Acquisition gate flip-flop
    trig_fall = s.trig_prev & ~s.sync2[0]; // [R26]
    next_s.trig_prev = s.sync2[0];
    gate_set = acq_enable & (trig_fall | (wr && io_addr == OFS_START)); // [R10]
    gate_clr = (sample_count_32 ? tc[4] : tc[3]) | overflow_err | overrun_err
             | (wr && io_addr == OFS_CLEAR); // [R11] [R14]
    if (gate_clr) begin
      next_s.gate_ff = 1'b0; // [R26]
    end else if (gate_set) begin
      next_s.gate_ff = 1'b1;
    end
    // Crossbar bus side
    a_sig = {1'b1, s.freq_out, s.out[4], s.sync2[2], s.out[1], s.out[0], s.sync2[3]};
    for (int j = 0; j < XBAR_LINES; j++) begin
      sel = s.xcfg[j*XBAR_FIELD +: 3];
      next_s.bus_out[j] = a_sig[sel > 3'h6 ? 3'h0 : sel]; // [R20]
      next_s.bus_oe[j] = s.xcfg[j*XBAR_FIELD + 3]; // [R20]
    end
    // Analog update and request
    upd_n = s.xcfg[XBAR_PIN_BASE + PIN_UPDATE*XBAR_FIELD + 3] ? a_in[PIN_UPDATE] : 1'b1;
    next_s.upd_prev = upd_n;
    upd_fall = s.upd_prev & ~upd_n;
    next_s.analog_update = waveform_gen_enable
                         & (upd_fall | (io_read && io_addr == OFS_UPDATE)); // [R18]
    next_s.update_request = update_request_mode & upd_fall; // [R19]
    // Host writes
    if (wr) begin
      unique case (io_addr)
        OFS_SHIFT: next_s.xshift = {io_wdata[0], s.xshift[XBAR_CFG_BITS-1:1]}; // [R21]
        OFS_LOAD: next_s.xcfg = s.xshift; // [R25]
        OFS_DATA: begin
          if (s.ptr < 3'(COUNTERS)) begin
            if (s.dsel == DSEL_MODE) next_s.mode[s.ptr] = io_wdata;
            else if (s.dsel == DSEL_LOAD) next_s.load[s.ptr] = io_wdata;
            else next_s.count[s.ptr] = io_wdata;
          end
        end
        OFS_CMD: begin
          unique case (cmd_op_t'(io_wdata[CMD_OP_LSB +: 3]))
            CMD_POINT: begin
              next_s.ptr = io_wdata[2:0];
              next_s.dsel = io_wdata[CMD_DSEL_LSB +: 2];
            end
            CMD_ARM: next_s.armed = s.armed | COUNTERS'(io_wdata[4:0]);
            CMD_DISARM: next_s.armed = s.armed & ~COUNTERS'(io_wdata[4:0]);
            CMD_LOAD: begin
              for (int i = 0; i < COUNTERS; i++) begin
                if (io_wdata[i]) next_s.count[i] = s.load[i];
              end
            end
            CMD_FREQ: begin
              next_s.freq_src = io_wdata[CMD_FSRC_LSB +: 4];
              next_s.freq_div = io_wdata[CMD_FDIV_LSB +: 4];
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    // Host reads
    if (io_read) begin
      rd = 16'h0000;
      if (io_addr == OFS_STATUS) begin
        rd = {5'h00, s.gate_ff, s.dsel, s.ptr, s.out};
      end else if (io_addr == OFS_DATA && s.ptr < 3'(COUNTERS)) begin
        rd = (s.dsel == DSEL_MODE) ? s.mode[s.ptr]
           : (s.dsel == DSEL_LOAD) ? s.load[s.ptr] : s.count[s.ptr];
      end
      next_s.rdata = rd;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.mode <= {COUNTERS{MODE_RESET}};
      s.load <= {COUNTERS{LOAD_RESET}};
      s.freq_div <= FREQ_DIV_RESET;
      s.sync1 <= '1;
      s.sync2 <= '1;
      s.trig_prev <= 1'b1;
      s.upd_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign io_rdata = s.rdata;
  assign counter_out = s.out; // [R16]
  assign counter_out_oe = s.oe;
  assign divided_frequency_out = s.freq_out;
  assign counter4_gate = s.gate_ff; // [R12]
  assign channel_list_clock = s.list_clk;
  assign analog_update = s.analog_update;
  assign update_request = s.update_request;
  assign trig_bus_out = s.bus_out;
  assign trig_bus_oe = s.bus_oe;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_gate_set_cause: assert property ($rose(counter4_gate) |-> $past(gate_set)) // [R10]
    else $error("gate set without trigger or start");
  a_gate_clear_wins: assert property (gate_clr |=> !counter4_gate) // [R26]
    else $error("gate not cleared");
  a_start_sets: assert property (acq_enable && io_write && io_addr == OFS_START && !gate_clr
    |=> counter4_gate) // [R10]
    else $error("start write did not set gate");
  a_clear_write: assert property (io_write && io_addr == OFS_CLEAR |=> !counter4_gate) // [R11]
    else $error("clear write did not clear gate");
  a_pulse_one: assert property (s.mode[0][15:10] == 6'h00
    && $rose(counter_out[0]) |=> !counter_out[0]) // [R7]
    else $error("pulse longer than one cycle");
  a_toggle_flip: assert property (tc[0] && s.mode[0][MODE_TOGGLE_BIT]
    && s.mode[0][13:12] == OUT_NORMAL |=> $changed(counter_out[0])) // [R8]
    else $error("toggle output did not change");
  a_hiz_release: assert property (s.mode[0][13:12] == OUT_HIZ |=> !counter_out_oe[0]) // [R5]
    else $error("output enable not released");
  a_low_drive: assert property (s.mode[0][13:12] == OUT_LOW
    |=> counter_out_oe[0] && !counter_out[0]) // [R5]
    else $error("grounded output not driven low");
  a_xbar_load: assert property (io_write && io_addr == OFS_LOAD
    |=> s.xcfg == $past(s.xshift)) // [R25]
    else $error("crossbar pattern not transferred");
  a_update_cause: assert property (analog_update |-> $past(waveform_gen_enable)) // [R18]
    else $error("analog update without waveform enable");

  c_gate_run: cover property ($rose(counter4_gate) ##[1:200] $fell(counter4_gate));
  c_sample_end: cover property (tc[3] && counter4_gate);
  c_update: cover property (analog_update);
endmodule

// ---- pkg/timing_io_pkg.sv ----
// Constants for the counter, trigger-gate and trigger-crossbar block.
// Assumes an 8-bit/16-bit host register port synchronous to the board clock.
package timing_io_pkg;
  // Host register offsets
  localparam logic [4:0] OFS_START = 5'h0A;
  localparam logic [4:0] OFS_CLEAR = 5'h0C;
  localparam logic [4:0] OFS_UPDATE = 5'h0E;
  localparam logic [4:0] OFS_DATA = 5'h18;
  localparam logic [4:0] OFS_CMD = 5'h1A;
  localparam logic [4:0] OFS_STATUS = 5'h1A;
  localparam logic [4:0] OFS_SHIFT = 5'h1E;
  localparam logic [4:0] OFS_LOAD = 5'h1F;
  // Counter mode word fields
  localparam int MODE_SRC_LSB = 0;
  localparam int MODE_EDGE_BIT = 4;
  localparam int MODE_GATE_LSB = 5;
  localparam int MODE_RELOAD_BIT = 8;
  localparam int MODE_DOWN_BIT = 9;
  localparam int MODE_TOGGLE_BIT = 10;
  localparam int MODE_INVERT_BIT = 11;
  localparam int MODE_OUT_LSB = 12;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] LOAD_RESET = 16'h0000;
  typedef enum logic [2:0] {
    GATE_NONE = 3'h0, GATE_HIGH = 3'h1, GATE_LOW = 3'h2, GATE_RISE = 3'h3,
    GATE_FALL = 3'h4, GATE_NEXT = 3'h5, GATE_PREV = 3'h6
  } gate_mode_t;
  typedef enum logic [1:0] {OUT_NORMAL = 2'h0, OUT_HIZ = 2'h1, OUT_LOW = 2'h2} out_ctl_t;
  // Command word: operation in the top bits
  localparam int CMD_OP_LSB = 13;
  typedef enum logic [2:0] {
    CMD_POINT = 3'h0, CMD_ARM = 3'h1, CMD_DISARM = 3'h2, CMD_LOAD = 3'h3, CMD_FREQ = 3'h4
  } cmd_op_t;
  localparam int CMD_DSEL_LSB = 3;
  localparam int CMD_FSRC_LSB = 4;
  localparam int CMD_FDIV_LSB = 8;
  localparam logic [1:0] DSEL_MODE = 2'h0;
  localparam logic [1:0] DSEL_LOAD = 2'h1;
  localparam logic [1:0] DSEL_COUNT = 2'h2;
  localparam logic [3:0] FREQ_DIV_RESET = 4'h0;
  // Clock rates
  localparam int BOARD_CLK_HZ = 10_000_000;
  localparam int COUNTER_CLK_HZ = 1_000_000;
  localparam int PRESCALE_CYCLES = BOARD_CLK_HZ / COUNTER_CLK_HZ;
  localparam int DECADE_RATIO = 10;
  // Crossbar layout
  localparam int XBAR_LINES = 7;
  localparam int XBAR_FIELD = 4;
  localparam int XBAR_PIN_BASE = XBAR_LINES * XBAR_FIELD;
  localparam int XBAR_CFG_BITS = 2 * XBAR_PIN_BASE;
  localparam int PIN_SRC5 = 3;
  localparam int PIN_UPDATE = 6;
endpackage

// ---- testbench/host_pin_model.sv ----
// Host register port and connector pin model for the timing block.
// Assumes strobes launch just after a rising ref_clk edge; pins rest high.
`timescale 1ns/10ps
module host_pin_model
  import timing_io_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Host register port
  output logic [4:0] io_addr,
  output logic [15:0] io_wdata,
  output logic io_write,
  output logic io_read,
  input wire logic [15:0] io_rdata,
  // Connector pins
  output logic ext_trigger_n,
  output logic [1:0] source_pin,
  output logic [2:0] gate_pin,
  output logic [XBAR_LINES-1:0] trig_bus_in
);
  initial begin
    io_addr = 5'h00;
    io_wdata = 16'h0000;
    io_write = 1'b0;
    io_read = 1'b0;
    ext_trigger_n = 1'b1;
    source_pin = 2'h3;
    gate_pin = 3'h7;
    trig_bus_in = 7'h7F;
  end
  // Released bus shows the inverse of the last value
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_wdata <= d;
    io_write <= 1'b1;
    @(posedge ref_clk);
    io_write <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask
  task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_read <= 1'b1;
    @(posedge ref_clk);
    io_read <= 1'b0;
    io_addr <= ~a;
    @(posedge ref_clk);
    d = io_rdata;
  endtask
  task automatic pulse_trigger();
    @(posedge ref_clk);
    ext_trigger_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ext_trigger_n <= 1'b1;
  endtask
  task automatic pulse_bus(input int k);
    @(posedge ref_clk);
    trig_bus_in[k] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    trig_bus_in[k] <= 1'b1;
  endtask
  task automatic set_gate1(input logic v);
    @(posedge ref_clk);
    gate_pin[0] <= v;
  endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the timing block.
// Assumes the host and pin model drives the register port and connector pins.
`timescale 1ns/10ps
module tb
  import timing_io_pkg::*;
;
  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic gate;
  } reg_row_t;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] io_addr;
  logic [15:0] io_wdata, io_rdata, rd;
  logic io_write, io_read, ext_trigger_n, divided_frequency_out, counter4_gate;
  logic acq_enable, waveform_gen_enable, update_request_mode, overflow_err, overrun_err;
  logic tie_lo = 1'b0;
  logic scan_divide = 1'b0;
  logic scan_pacing_clock = 1'b0;
  logic channel_list_clock, analog_update, update_request, probe;
  logic [1:0] source_pin;
  logic [2:0] gate_pin;
  logic [4:0] counter_out, counter_out_oe;
  logic [6:0] trig_bus_in, trig_bus_out, trig_bus_oe;
  logic [55:0] pat = 56'h90_0000_0000_000E;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  int probe_sel = 0;
  int rises, maxw, per;
  reg_row_t rows [13] = '{
    '{1'b0, OFS_STATUS, 16'h0000, 16'h0000, 1'b0},
    '{1'b1, OFS_START, 16'h00A5, 16'h0000, 1'b1},
    '{1'b0, OFS_STATUS, 16'h0000, 16'h0400, 1'b1},
    '{1'b1, OFS_CLEAR, 16'h005A, 16'h0000, 1'b0},
    '{1'b1, OFS_CMD, 16'h0005, 16'h0000, 1'b0},
    '{1'b0, OFS_DATA, 16'h0000, 16'h0000, 1'b0},
    '{1'b1, OFS_CMD, 16'h0001, 16'h0000, 1'b0},
    '{1'b0, OFS_STATUS, 16'h0000, 16'h0020, 1'b0},
    '{1'b0, 5'h02, 16'h0000, 16'h0000, 1'b0},
    '{1'b1, OFS_CMD, 16'h0008, 16'h0000, 1'b0},
    '{1'b1, OFS_DATA, 16'h0003, 16'h0000, 1'b0},
    '{1'b1, OFS_CMD, 16'h0008, 16'h0000, 1'b0},
    '{1'b0, OFS_DATA, 16'h0000, 16'h0003, 1'b0}};

  always #50 ref_clk = ~ref_clk;

  host_pin_model host (.ref_clk(ref_clk), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_write(io_write), .io_read(io_read), .io_rdata(io_rdata),
    .ext_trigger_n(ext_trigger_n), .source_pin(source_pin), .gate_pin(gate_pin),
    .trig_bus_in(trig_bus_in));

  timing_io dut (.ref_clk(ref_clk), .rst_b(rst_b), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_write(io_write), .io_read(io_read), .io_rdata(io_rdata), .acq_enable(acq_enable),
    .sample_count_32(tie_lo), .scan_divide(scan_divide),
    .waveform_gen_enable(waveform_gen_enable), .update_request_mode(update_request_mode),
    .overflow_err(overflow_err), .overrun_err(overrun_err),
    .scan_pacing_clock(scan_pacing_clock),
    .acq_gate3(tie_lo), .ext_trigger_n(ext_trigger_n), .source_pin(source_pin),
    .gate_pin(gate_pin), .counter_out(counter_out), .counter_out_oe(counter_out_oe),
    .divided_frequency_out(divided_frequency_out), .counter4_gate(counter4_gate),
    .channel_list_clock(channel_list_clock), .analog_update(analog_update),
    .update_request(update_request), .trig_bus_in(trig_bus_in),
    .trig_bus_out(trig_bus_out), .trig_bus_oe(trig_bus_oe));

  always_comb
    case (probe_sel)
      0: probe = counter_out[0];
      1: probe = ~counter_out[0];
      2: probe = divided_frequency_out;
      3: probe = analog_update;
      default: probe = update_request;
    endcase

  task automatic final_report();
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Run away guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      final_report();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Counts rising edges, longest high run and last rise spacing
  task automatic observe(input int sel, input int n);
    int run, t0;
    logic prev;
    probe_sel = sel;
    run = 0;
    t0 = -1;
    rises = 0;
    maxw = 0;
    per = 0;
    @(posedge ref_clk);
    #1;
    prev = probe;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      run = (probe === 1'b1) ? run + 1 : 0;
      if (run > maxw) maxw = run;
      if (probe === 1'b1 && prev !== 1'b1) begin
        rises++;
        if (t0 >= 0) per = i - t0;
        t0 = i;
      end
      prev = probe;
    end
  endtask

  task automatic set_mode(input logic [15:0] m);
    host.reg_write(OFS_CMD, 16'h0000);
    host.reg_write(OFS_DATA, m);
  endtask

  task automatic gate_is(input logic v);
    @(posedge ref_clk);
    #1;
    check({15'h0, counter4_gate}, {15'h0, v});
  endtask

  initial begin
    acq_enable = 1'b0;
    waveform_gen_enable = 1'b0;
    update_request_mode = 1'b0;
    overflow_err = 1'b0;
    overrun_err = 1'b0;
    repeat (11) @(posedge ref_clk);
    #1;
    check({11'h0, counter_out_oe}, 16'h0000);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    #1;
    check({11'h0, counter_out_oe}, 16'h001F);
    check({11'h0, counter_out}, 16'h0000);
    $display("reset test done");
    @(posedge ref_clk);
    acq_enable <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) host.reg_write(rows[i].addr, rows[i].wdata);
      else begin
        host.reg_read(rows[i].addr, rd);
        check(rd, rows[i].rdata);
      end
      gate_is(rows[i].gate);
    end
    $display("register table test done");
    host.reg_write(OFS_CMD, 16'h0008);
    host.reg_write(OFS_DATA, 16'h0004);
    set_mode(16'h0300);
    host.reg_write(OFS_CMD, 16'h6001);
    host.reg_write(OFS_CMD, 16'h2001);
    observe(0, 300);
    check({15'h0, rises >= 2}, 16'h0001);
    check(16'(maxw), 16'h0001);
    set_mode(16'h0B00);
    observe(1, 300);
    check({15'h0, rises >= 2}, 16'h0001);
    check(16'(maxw), 16'h0001);
    set_mode(16'h0700);
    observe(0, 300);
    check({15'h0, rises >= 1 && maxw > 1}, 16'h0001);
    host.set_gate1(1'b0);
    set_mode(16'h0320);
    observe(0, 200);
    check(16'(rises), 16'h0000);
    host.set_gate1(1'b1);
    observe(0, 300);
    check({15'h0, rises >= 2}, 16'h0001);
    set_mode(16'h1300);
    @(posedge ref_clk);
    #1;
    check({15'h0, counter_out_oe[0]}, 16'h0000);
    set_mode(16'h2300);
    observe(0, 200);
    check({15'h0, counter_out_oe[0]}, 16'h0001);
    check(16'(rises), 16'h0000);
    $display("counter test done");
    @(posedge ref_clk);
    acq_enable <= 1'b0;
    host.pulse_trigger();
    repeat (6) @(posedge ref_clk);
    gate_is(1'b0);
    @(posedge ref_clk);
    acq_enable <= 1'b1;
    host.pulse_trigger();
    repeat (6) @(posedge ref_clk);
    gate_is(1'b1);
    @(posedge ref_clk);
    overflow_err <= 1'b1;
    @(posedge ref_clk);
    overflow_err <= 1'b0;
    gate_is(1'b0);
    host.reg_write(OFS_START, 16'h0001);
    gate_is(1'b1);
    @(posedge ref_clk);
    overrun_err <= 1'b1;
    @(posedge ref_clk);
    overrun_err <= 1'b0;
    gate_is(1'b0);
    fork
      host.reg_write(OFS_START, 16'h0001);
      begin
        @(posedge ref_clk);
        overflow_err <= 1'b1;
        @(posedge ref_clk);
        overflow_err <= 1'b0;
      end
    join
    gate_is(1'b0);
    $display("trigger gate test done");
    for (int i = 0; i < 56; i++) host.reg_write(OFS_SHIFT, {15'h0, pat[i]});
    gate_is(1'b0);
    check({9'h0, trig_bus_oe}, 16'h0000);
    host.reg_write(OFS_LOAD, 16'h0000);
    repeat (2) @(posedge ref_clk);
    #1;
    check({9'h0, trig_bus_oe}, 16'h0001);
    check({15'h0, trig_bus_out[0]}, 16'h0001);
    $display("crossbar test done");
    host.reg_write(OFS_CMD, 16'h8200);
    observe(2, 100);
    check(16'(per), 16'h0014);
    check(16'(maxw), 16'h000A);
    $display("frequency test done");
    @(posedge ref_clk);
    waveform_gen_enable <= 1'b1;
    update_request_mode <= 1'b1;
    fork
      host.reg_read(OFS_UPDATE, rd);
      observe(3, 10);
    join
    check(16'(rises), 16'h0001);
    for (int s = 3; s < 5; s++) begin
      fork
        host.pulse_bus(1);
        observe(s, 10);
      join
      check(16'(rises), 16'h0001);
    end
    @(posedge ref_clk);
    waveform_gen_enable <= 1'b0;
    fork
      host.reg_read(OFS_UPDATE, rd);
      observe(3, 10);
    join
    check(16'(rises), 16'h0000);
    $display("update test done");
    @(posedge ref_clk);
    scan_pacing_clock <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check({15'h0, channel_list_clock}, 16'h0001);
    @(posedge ref_clk);
    scan_divide <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check({15'h0, channel_list_clock}, 16'h0000);
    $display("list clock test done");
    final_report();
  end
endmodule
